// file: rtl/cbu_defs.svh
`ifndef CBU_DEFS_SVH
`define CBU_DEFS_SVH

// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define CBU_FLAG_C 3'h0
`define CBU_FLAG_Z 3'h1
`define CBU_FLAG_N 3'h2
`define CBU_FLAG_V 3'h3
`define CBU_FLAG_S 3'h4
`define CBU_FLAG_H 3'h5
`define CBU_FLAG_T 3'h6
`define CBU_FLAG_I 3'h7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define CBU_PC_W 17
`define CBU_K_W 7
`define CBU_PC_RST 17'h0_0000
`define CBU_PC_ONE 17'h0_0001

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN 2'h2

`endif

// file: rtl/cbu_pkg.sv
package cbu_pkg;

  // ----------------------------------------
  // Branch operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    branch_status_bit_clear = 4'h0,
    branch_status_bit_set = 4'h1,
    branch_equal = 4'h2,
    branch_not_equal = 4'h3,
    branch_carry_set = 4'h4,
    branch_carry_clear = 4'h5,
    branch_negative = 4'h6,
    branch_positive = 4'h7,
    branch_signed_greater_equal = 4'h8,
    branch_signed_less = 4'h9,
    branch_half_carry_set = 4'ha,
    branch_half_carry_clear = 4'hb,
    branch_transfer_bit_set = 4'hc,
    branch_transfer_bit_clear = 4'hd
  } cbu_op_e;

  // Aliases that share a condition
  localparam cbu_op_e branch_unsigned_same_or_higher = branch_carry_clear;
  localparam cbu_op_e branch_unsigned_lower = branch_carry_set;

  // ----------------------------------------
  // Request and answer carriers
  // ----------------------------------------
  typedef struct packed {
    cbu_op_e op;
    logic [2:0] sel;
    logic [6:0] k;
    logic [16:0] pc;
  } cbu_req_s;

  typedef struct packed {
    logic load;
    logic [16:0] pc;
  } cbu_rsp_s;

  typedef enum logic [1:0] {
    cbu_idle = 2'b00,
    cbu_jump = 2'b01
  } cbu_state_e;

endpackage : cbu_pkg

// file: rtl/cbu_cond_eval.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbu_defs.svh"

module cbu_cond_eval (
  input wire cbu_pkg::cbu_op_e i_op,
  input wire logic [2:0] i_sel,
  input wire logic [7:0] i_flags,
  output logic o_taken
);

  // ----------------------------------------
  // Flag picks
  // ----------------------------------------
  wire logic f_c = i_flags[`CBU_FLAG_C];
  wire logic f_z = i_flags[`CBU_FLAG_Z];
  wire logic f_n = i_flags[`CBU_FLAG_N];
  wire logic f_v = i_flags[`CBU_FLAG_V];
  wire logic f_h = i_flags[`CBU_FLAG_H];
  wire logic f_t = i_flags[`CBU_FLAG_T];
  wire logic f_sel = i_flags[i_sel];
  wire logic f_sign = f_n ^ f_v;

  // ----------------------------------------
  // Condition select
  // ----------------------------------------
  always_comb begin
    unique case (i_op)
      cbu_pkg::branch_status_bit_clear: o_taken = ~f_sel;
      cbu_pkg::branch_status_bit_set: o_taken = f_sel;
      cbu_pkg::branch_equal: o_taken = f_z;
      cbu_pkg::branch_not_equal: o_taken = ~f_z;
      cbu_pkg::branch_carry_set: o_taken = f_c;
      cbu_pkg::branch_carry_clear: o_taken = ~f_c;
      cbu_pkg::branch_negative: o_taken = f_n;
      cbu_pkg::branch_positive: o_taken = ~f_n;
      cbu_pkg::branch_signed_greater_equal: o_taken = ~f_sign;
      cbu_pkg::branch_signed_less: o_taken = f_sign;
      cbu_pkg::branch_half_carry_set: o_taken = f_h;
      cbu_pkg::branch_half_carry_clear: o_taken = ~f_h;
      cbu_pkg::branch_transfer_bit_set: o_taken = f_t;
      cbu_pkg::branch_transfer_bit_clear: o_taken = ~f_t;
      default: o_taken = 1'b0;
    endcase
  end

endmodule : cbu_cond_eval
`default_nettype wire

// file: rtl/cbu_branch_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbu_defs.svh"

module cbu_branch_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire cbu_pkg::cbu_req_s i_req,
  input wire logic [7:0] i_flags,
  output logic o_busy,
  output logic o_done,
  output logic o_taken,
  output cbu_pkg::cbu_rsp_s o_rsp
);

  // ----------------------------------------
  // Condition and target
  // ----------------------------------------
  logic cond_taken;
  cbu_pkg::cbu_state_e state_r;
  cbu_pkg::cbu_state_e state_nxt;
  logic busy_r;
  logic done_r;
  logic taken_r;
  cbu_pkg::cbu_rsp_s rsp_r;
  cbu_pkg::cbu_rsp_s rsp_nxt;

  cbu_cond_eval cbu_cond_eval_inst (
    .i_op(i_req.op),
    .i_sel(i_req.sel),
    .i_flags(i_flags),
    .o_taken(cond_taken)
  );

  wire logic accept = i_valid && (state_r == cbu_pkg::cbu_idle);
  wire logic [16:0] k_ext = {{10{i_req.k[6]}}, i_req.k};
  wire logic [16:0] pc_seq = i_req.pc + `CBU_PC_ONE;
  wire logic [16:0] pc_jump = pc_seq + k_ext;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cbu_pkg::cbu_idle: begin
        if (accept && cond_taken) begin
          state_nxt = cbu_pkg::cbu_jump;
        end
      end
      cbu_pkg::cbu_jump: state_nxt = cbu_pkg::cbu_idle;
      default: state_nxt = cbu_pkg::cbu_idle;
    endcase
  end

  always_comb begin
    rsp_nxt = '0;
    if (accept) begin
      rsp_nxt.load = 1'b1;
      rsp_nxt.pc = cond_taken ? pc_jump : pc_seq;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= cbu_pkg::cbu_idle;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      taken_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      state_r <= state_nxt;
      busy_r <= accept && cond_taken;
      done_r <= (accept && !cond_taken) || (state_r == cbu_pkg::cbu_jump);
      taken_r <= state_r == cbu_pkg::cbu_jump;
      rsp_r <= rsp_nxt;
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_taken = taken_r;
  assign o_rsp = rsp_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_taken_two: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && cond_taken) |=> busy_r ##1 (done_r && taken_r))
    else $error("taken branch not done in two cycles");

  a_skip_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && !cond_taken) |=> (done_r && !taken_r && !busy_r))
    else $error("untaken branch not done in one cycle");

  a_target_pc: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && cond_taken) |=> (rsp_r.load && rsp_r.pc == $past(pc_jump)))
    else $error("taken target wrong");

  a_seq_pc: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && !cond_taken) |=> (rsp_r.pc == $past(pc_seq)))
    else $error("sequential pc wrong");

  a_carry_cond: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_carry_clear) |-> (cond_taken == !i_flags[0]))
    else $error("carry clear condition wrong");

  a_sign_ge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_signed_greater_equal)
      |-> (cond_taken == !(i_flags[2] ^ i_flags[3])))
    else $error("signed ge condition wrong");

  a_sign_lt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_signed_less)
      |-> (cond_taken == (i_flags[2] ^ i_flags[3])))
    else $error("signed lt condition wrong");

  a_half_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_half_carry_set) |-> (cond_taken == i_flags[5]))
    else $error("half set condition wrong");

  a_half_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_half_carry_clear) |-> (cond_taken == !i_flags[5]))
    else $error("half clear condition wrong");

  a_tbit_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_transfer_bit_set) |-> (cond_taken == i_flags[6]))
    else $error("t set condition wrong");

  a_tbit_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_transfer_bit_clear) |-> (cond_taken == !i_flags[6]))
    else $error("t clear condition wrong");

  a_zero_eq: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_equal) |-> (cond_taken == i_flags[1]))
    else $error("equal condition wrong");

  // ----------------------------------------
  // Further conditions and sequencing
  // ----------------------------------------

  a_zero_ne: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_not_equal)
      |-> (cond_taken == !i_flags[`CBU_FLAG_Z]))
    else $error("not equal condition wrong");

  a_carry_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_unsigned_lower)
      |-> (cond_taken == i_flags[`CBU_FLAG_C]))
    else $error("carry set condition wrong");

  a_neg_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_negative)
      |-> (cond_taken == i_flags[`CBU_FLAG_N]))
    else $error("minus condition wrong");

  a_neg_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_positive)
      |-> (cond_taken == !i_flags[`CBU_FLAG_N]))
    else $error("plus condition wrong");

  a_sbit_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_status_bit_clear)
      |-> (cond_taken == !i_flags[i_req.sel]))
    else $error("status bit clear condition wrong");

  a_sbit_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op == cbu_pkg::branch_status_bit_set)
      |-> (cond_taken == i_flags[i_req.sel]))
    else $error("status bit set condition wrong");

  a_bad_op: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && i_req.op > cbu_pkg::branch_transfer_bit_clear)
      |-> !cond_taken)
    else $error("unused op code taken");

  a_target_sum: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && cond_taken)
      |=> (rsp_r.pc == ($past(i_req.pc) + $past({{10{i_req.k[6]}}, i_req.k}) + `CBU_PC_ONE)))
    else $error("taken target sum wrong");

  a_seq_sum: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && !cond_taken)
      |=> (rsp_r.load && rsp_r.pc == ($past(i_req.pc) + `CBU_PC_ONE)))
    else $error("sequential sum wrong");

  a_refuse_busy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_r == cbu_pkg::cbu_jump)
      |=> (!busy_r && !rsp_r.load))
    else $error("request accepted while busy");

  a_untaken_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (accept && !cond_taken)
      |-> ##2 !taken_r)
    else $error("untaken branch marked taken");

  a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_valid && state_r == cbu_pkg::cbu_idle)
      |=> (!busy_r && !done_r && !rsp_r.load))
    else $error("output without request");

  a_taken_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    taken_r
      |-> (done_r && !busy_r))
    else $error("taken without done");

  a_rsp_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !rsp_r.load
      |-> (rsp_r.pc == 17'h0_0000))
    else $error("target shown without load");

  a_busy_once: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    busy_r
      |=> !busy_r)
    else $error("busy held too long");

endmodule : cbu_branch_unit
`default_nettype wire

// file: dv/cbu_branch_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module cbu_branch_unit_test;
  logic i_sys_clk;
  logic i_rst;
  logic i_valid;
  cbu_pkg::cbu_req_s i_req;
  logic [7:0] i_flags;
  logic o_busy;
  logic o_done;
  logic o_taken;
  cbu_pkg::cbu_rsp_s o_rsp;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed_val;

  cbu_branch_unit cbu_branch_unit_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_valid(i_valid),
    .i_req(i_req),
    .i_flags(i_flags),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_taken(o_taken),
    .o_rsp(o_rsp)
  );

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  // ----------------------------------------
  // Checking and expectation
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic cond(input logic [3:0] op, input logic [2:0] sel,
                                input logic [7:0] fl);
    case (op)
      4'h0: cond = ~fl[sel];
      4'h1: cond = fl[sel];
      4'h2: cond = fl[1];
      4'h3: cond = ~fl[1];
      4'h4: cond = fl[0];
      4'h5: cond = ~fl[0];
      4'h6: cond = fl[2];
      4'h7: cond = ~fl[2];
      4'h8: cond = ~(fl[2] ^ fl[3]);
      4'h9: cond = fl[2] ^ fl[3];
      4'ha: cond = fl[5];
      4'hb: cond = ~fl[5];
      4'hc: cond = fl[6];
      4'hd: cond = ~fl[6];
      default: cond = 1'b0;
    endcase
  endfunction : cond

  // ----------------------------------------
  // One branch, with an optional request while busy
  // ----------------------------------------
  task automatic run(input logic [3:0] op, input logic [2:0] sel, input logic [6:0] k,
                     input logic [16:0] pc, input logic [7:0] fl, input logic poke);
    logic t;
    logic [16:0] tgt;
    t = cond(op, sel, fl);
    tgt = t ? pc + {{10{k[6]}}, k} + 17'h0_0001 : pc + 17'h0_0001;
    @(posedge i_sys_clk);
    i_valid <= 1'b1;
    i_req <= '{op: cbu_pkg::cbu_op_e'(op), sel: sel, k: k, pc: pc};
    i_flags <= fl;
    @(posedge i_sys_clk);
    i_valid <= poke & t;
    #1;
    chk({17'h0_0000, o_rsp.load}, 18'h0_0001);
    chk({1'b0, o_rsp.pc}, {1'b0, tgt});
    chk({17'h0_0000, o_busy}, {17'h0_0000, t});
    chk({17'h0_0000, o_done}, {17'h0_0000, ~t});
    chk({17'h0_0000, o_taken}, 18'h0_0000);
    @(posedge i_sys_clk);
    i_valid <= 1'b0;
    #1;
    chk({17'h0_0000, o_done}, {17'h0_0000, t});
    chk({17'h0_0000, o_taken}, {17'h0_0000, t});
    chk(o_rsp, 18'h0_0000);
    chk({17'h0_0000, o_busy}, 18'h0_0000);
  endtask : run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_req = '0;
    i_flags = 8'h00;
    seed_val = $urandom(23);
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    chk(o_rsp, 18'h0_0000);
    chk({15'h0000, o_busy, o_done, o_taken}, 18'h0_0000);
    for (int op = 0; op < 16; op++) begin
      run(4'(op), 3'h5, 7'h03, 17'h0_0100, 8'h00, 1'b0);
      run(4'(op), 3'h5, 7'h7d, 17'h0_0100, 8'hff, 1'b0);
      run(4'(op), 3'h2, 7'h10, 17'h0_0200, 8'h04, 1'b0);
    end
    for (int s = 0; s < 8; s++) begin
      run(4'h0, 3'(s), 7'h05, 17'h0_0040, ~(8'h01 << s), 1'b0);
      run(4'h1, 3'(s), 7'h05, 17'h0_0040, 8'h01 << s, 1'b0);
    end
    run(4'h1, 3'h0, 7'h01, 17'h1_ffff, 8'h01, 1'b0);
    run(4'h0, 3'h0, 7'h40, 17'h0_0010, 8'h00, 1'b0);
    run(4'hc, 3'h0, 7'h3f, 17'h0_1000, 8'h40, 1'b1);
    repeat (400) begin
      run(4'($urandom_range(15)), 3'($urandom_range(7)), 7'($urandom),
          17'($urandom), 8'($urandom), 1'($urandom));
    end
    // Reset in the busy cycle of a taken branch, then a wrapping branch
    @(posedge i_sys_clk);
    i_valid <= 1'b1;
    i_req <= '{op: cbu_pkg::branch_transfer_bit_set, sel: 3'h0, k: 7'h01, pc: 17'h0_0020};
    i_flags <= 8'h40;
    @(posedge i_sys_clk);
    i_valid <= 1'b0;
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk(o_rsp, 18'h0_0000);
    chk({15'h0000, o_busy, o_done, o_taken}, 18'h0_0000);
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    run(4'hc, 3'h0, 7'h7f, 17'h0_0000, 8'h40, 1'b0);
    results();
  end
endmodule : cbu_branch_unit_test
`default_nettype wire
